// ===== src/dri_pkg.sv
package dri_pkg;

  // ==========================================================================
  // Timing
  localparam int DRI_CLK_MHZ    = 125;
  localparam int DRI_T_INIT_US  = 500;
  localparam int DRI_INIT_CYC   = DRI_T_INIT_US * DRI_CLK_MHZ;
  localparam int DRI_DLLK_TCK   = 512;
  localparam int DRI_ZQINIT_TCK = 512;
  localparam int DRI_WAIT_W     = 12;
  localparam int DRI_INIT_W     = 17;

  // ==========================================================================
  // Register map
  localparam logic [7:0] DRI_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DRI_OFS_STATUS = 8'h04;
  localparam logic [7:0] DRI_OFS_BANK   = 8'h08;
  localparam logic [7:0] DRI_OFS_ORDER  = 8'h0c;
  localparam logic [7:0] DRI_OFS_MR0    = 8'h10;
  localparam logic [7:0] DRI_OFS_MR1    = 8'h14;
  localparam logic [7:0] DRI_OFS_MR2    = 8'h18;
  localparam logic [7:0] DRI_OFS_MR3    = 8'h1c;
  localparam logic [7:0] DRI_OFS_LAST   = 8'h20;
  localparam int         DRI_CTRL_EN    = 0;
  localparam int         DRI_CTRL_CLR   = 1;
  localparam logic [1:0] DRI_CTRL_RST   = 2'h1;

  // ==========================================================================
  // Command and address fields
  localparam logic [2:0] DRI_CMD_MRS = 3'h0;
  localparam logic [2:0] DRI_CMD_PRE = 3'h2;
  localparam logic [2:0] DRI_CMD_ACT = 3'h3;
  localparam logic [2:0] DRI_CMD_WR  = 3'h4;
  localparam logic [2:0] DRI_CMD_RD  = 3'h5;
  localparam logic [2:0] DRI_CMD_ZQ  = 3'h6;
  localparam int         DRI_A_AP      = 10;
  localparam int         DRI_A_BC      = 12;
  localparam int         DRI_A_DLLRST  = 8;
  localparam int         DRI_MR0_BT    = 3;
  localparam logic [1:0] DRI_BL_OTF    = 2'h1;
  localparam logic [1:0] DRI_BL_FIX4   = 2'h2;
  localparam int         DRI_NBANK     = 8;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic        rst_n;
    logic        cke;
    logic        odt;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        ck;
    logic [2:0]  ba;
    logic [15:0] a;
  } dri_pins_t;

  typedef enum logic [2:0] {
    ST_RST      = 3'h0,
    ST_INIT     = 3'h1,
    ST_WAIT_CKE = 3'h2,
    ST_MRS      = 3'h3,
    ST_CAL      = 3'h4,
    ST_READY    = 3'h5
  } dri_state_t;

endpackage

// ===== src/dri_burst_order.sv
`timescale 1ns/100ps
module dri_burst_order
  import dri_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Burst request
  input  wire logic        load,
  input  wire logic [2:0]  start,
  input  wire logic        interleave,
  input  wire logic        chop,
  input  wire logic        is_wr,
  // Beat order, three bits per beat
  output logic      [23:0] order_q
);

  logic [23:0] order_d;
  logic [2:0]  s;

  // ==========================================================================
  // Start column, writes align to the burst boundary
  always_comb
  begin
    s = start;
    if (is_wr)
      s = chop ? {start[2], 2'h0} : 3'h0;
  end

  // ==========================================================================
  // Beat order
  for (genvar i = 0; i < 8; i++)
  begin : g_beat
    localparam logic [2:0] IB = 3'(i);
    assign order_d[3*i +: 3] = interleave ? (s ^ IB)
                             : {s[2] ^ IB[2], 2'(s[1:0] + IB[1:0])};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      order_q <= '0;
    else if (load)
      order_q <= order_d;
  end

  a_first_beat: assert property (@(posedge hclk) disable iff (!hresetn)
    load && !is_wr |=> order_q[2:0] == $past(start))
    else $error("first beat differs from start column");

endmodule // dri_burst_order

// ===== src/dri_init_core.sv
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Contract
// - 500 us after reset release the device initialises without clock.
// - Termination stays off during reset and until CKE first registered high.
// - Eight banks with 8n prefetch, two words per clock at pins.
// - Bursts are eight or chopped four, in programmed order from column; writes here start at the burst boundary, not the column.
// - Active takes bank and row; Active precedes read or write.
// - Read or write takes column; A10 auto precharge; A12 chops on fly.
// - Mode writes and DLL reset leave array contents unchanged.
module dri_init_core
  import dri_pkg::*;
#(
  parameter int INIT_CYC = DRI_INIT_CYC
)(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Device pins
  input  wire dri_pins_t   pins,
  // Device status
  output logic             term_en_q,
  output logic             dev_ready
);

  dri_pins_t               p1_q;
  dri_pins_t               p_q;
  logic                    ck_prev_q;
  logic                    ck_rise;
  dri_state_t              st_q;
  logic [DRI_INIT_W-1:0]   init_cnt_q;
  logic                    cke_seen_q;
  logic [2:0]              cmd;
  logic                    cmd_v;
  logic                    cmd_mrs;
  logic                    cmd_zq;
  logic                    cmd_act;
  logic                    cmd_pre;
  logic                    cmd_rw;
  logic                    rw_ok;
  logic                    chop;
  logic [15:0]             mr_q [4];
  logic [1:0]              ctrl_q;
  logic                    bank_clr;
  logic [DRI_NBANK-1:0]    bank_open_q;
  logic [15:0]             last_row_q;
  logic [9:0]              last_col_q;
  logic [2:0]              last_bank_q;
  logic                    last_chop_q;
  logic                    last_ap_q;
  logic [1:0]              wait_trig;
  logic [1:0]              wait_done;
  logic [23:0]             order_q;
  logic                    ph_wr_q;
  logic [7:0]              ph_adr_q;
  logic [31:0]             rd_d;
  logic [31:0]             hrdata_q;

  // ==========================================================================
  // Pin synchroniser and CK edge detect
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      p1_q      <= '0;
      p_q       <= '0;
      ck_prev_q <= 1'b0;
    end
    else
    begin
      p1_q      <= pins;
      p_q       <= p1_q;
      ck_prev_q <= p_q.ck;
    end
  end

  assign ck_rise = p_q.ck && !ck_prev_q;
  assign cmd     = {p_q.ras_n, p_q.cas_n, p_q.we_n};
  assign cmd_v   = ck_rise && p_q.cke && !p_q.cs_n && p_q.rst_n;
  assign cmd_mrs = cmd_v && cmd == DRI_CMD_MRS && (st_q == ST_MRS || st_q == ST_READY);
  assign cmd_zq  = cmd_v && cmd == DRI_CMD_ZQ && st_q != ST_INIT && st_q != ST_WAIT_CKE;
  assign cmd_act = cmd_v && cmd == DRI_CMD_ACT && dev_ready && ctrl_q[DRI_CTRL_EN];
  assign cmd_pre = cmd_v && cmd == DRI_CMD_PRE && dev_ready && ctrl_q[DRI_CTRL_EN];
  assign cmd_rw  = cmd_v && (cmd == DRI_CMD_RD || cmd == DRI_CMD_WR)
                   && dev_ready && ctrl_q[DRI_CTRL_EN];
  assign rw_ok   = cmd_rw && bank_open_q[p_q.ba];
  assign chop    = mr_q[0][1:0] == DRI_BL_FIX4
                   || (mr_q[0][1:0] == DRI_BL_OTF && !p_q.a[DRI_A_BC]);
  assign dev_ready = st_q == ST_READY;

  // ==========================================================================
  // Initialisation sequence
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_q <= ST_RST;
    else if (!p_q.rst_n)
      st_q <= ST_RST;
    else
      unique case (st_q)
        ST_RST:      st_q <= ST_INIT;
        ST_INIT:     if (init_cnt_q == DRI_INIT_W'(INIT_CYC - 1)) st_q <= ST_WAIT_CKE;
        ST_WAIT_CKE: if (ck_rise && p_q.cke) st_q <= ST_MRS;
        ST_MRS:      if (cmd_zq) st_q <= ST_CAL;
        ST_CAL:      if (&wait_done) st_q <= ST_READY;
        ST_READY:    st_q <= ST_READY;
        default:     st_q <= ST_RST;
      endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      init_cnt_q <= '0;
    else if (st_q == ST_INIT)
      init_cnt_q <= init_cnt_q + 1'b1;
    else
      init_cnt_q <= '0;
  end

  // ==========================================================================
  // Termination gate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cke_seen_q <= 1'b0;
    else if (!p_q.rst_n)
      cke_seen_q <= 1'b0;
    else if (ck_rise && p_q.cke && st_q != ST_RST)
      cke_seen_q <= 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      term_en_q <= 1'b0;
    else
      term_en_q <= p_q.rst_n && cke_seen_q && p_q.odt;
  end

  // ==========================================================================
  // DLL lock and calibration timers, counted in CK cycles
  assign wait_trig[0] = cmd_mrs && p_q.ba == 3'h0 && p_q.a[DRI_A_DLLRST];
  assign wait_trig[1] = cmd_zq;

  for (genvar i = 0; i < 2; i++)
  begin : g_wait
    localparam logic [DRI_WAIT_W-1:0] LEN = DRI_WAIT_W'(i == 0 ? DRI_DLLK_TCK : DRI_ZQINIT_TCK);
    logic [DRI_WAIT_W-1:0] left_q;
    logic                  armed_q;
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        left_q  <= '0;
        armed_q <= 1'b0;
      end
      else if (!p_q.rst_n)
      begin
        left_q  <= '0;
        armed_q <= 1'b0;
      end
      else if (wait_trig[i])
      begin
        left_q  <= LEN;
        armed_q <= 1'b1;
      end
      else if (ck_rise && left_q != '0)
        left_q <= left_q - 1'b1;
    end
    assign wait_done[i] = armed_q && left_q == '0;
  end

  // ==========================================================================
  // Mode registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      for (int j = 0; j < 4; j++) mr_q[j] <= '0;
    else if (cmd_mrs && !p_q.ba[2])
      mr_q[p_q.ba[1:0]] <= p_q.a;
  end

  // ==========================================================================
  // Bank state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bank_open_q <= '0;
    else if (!p_q.rst_n)
      bank_open_q <= '0;
    else if (cmd_act)
      bank_open_q <= (bank_clr ? '0 : bank_open_q) | DRI_NBANK'(1 << p_q.ba);
    else if (bank_clr || (cmd_pre && p_q.a[DRI_A_AP]))
      bank_open_q <= '0;
    else if (cmd_pre || (rw_ok && p_q.a[DRI_A_AP]))
      bank_open_q[p_q.ba] <= 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_row_q  <= '0;
      last_col_q  <= '0;
      last_bank_q <= '0;
      last_chop_q <= 1'b0;
      last_ap_q   <= 1'b0;
    end
    else if (cmd_act)
    begin
      last_row_q  <= p_q.a;
      last_bank_q <= p_q.ba;
    end
    else if (rw_ok)
    begin
      last_col_q  <= p_q.a[9:0];
      last_bank_q <= p_q.ba;
      last_chop_q <= chop;
      last_ap_q   <= p_q.a[DRI_A_AP];
    end
  end

  dri_burst_order u_order (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .load       (rw_ok),
    .start      (p_q.a[2:0]),
    .interleave (mr_q[0][DRI_MR0_BT]),
    .chop       (chop),
    .is_wr      (cmd == DRI_CMD_WR),
    .order_q    (order_q)
  );

  // ==========================================================================
  // AHB-Lite slave, zero wait states
  always_comb
  begin
    unique case (haddr[7:0])
      DRI_OFS_CTRL:   rd_d = {30'h0, ctrl_q};
      DRI_OFS_STATUS: rd_d = {24'h0, last_ap_q, last_chop_q, dev_ready, term_en_q,
                              cke_seen_q, st_q};
      DRI_OFS_BANK:   rd_d = {24'h0, bank_open_q};
      DRI_OFS_ORDER:  rd_d = {8'h0, order_q};
      DRI_OFS_MR0:    rd_d = {16'h0, mr_q[0]};
      DRI_OFS_MR1:    rd_d = {16'h0, mr_q[1]};
      DRI_OFS_MR2:    rd_d = {16'h0, mr_q[2]};
      DRI_OFS_MR3:    rd_d = {16'h0, mr_q[3]};
      DRI_OFS_LAST:   rd_d = {1'b0, last_bank_q, 2'h0, last_col_q, last_row_q};
      default:        rd_d = '0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr_q  <= 1'b0;
      ph_adr_q <= '0;
      hrdata_q <= '0;
    end
    else
    begin
      ph_wr_q  <= hsel && hready && htrans[1] && hwrite;
      ph_adr_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite)
        hrdata_q <= rd_d;
    end
  end

  assign bank_clr = ph_wr_q && ph_adr_q == DRI_OFS_CTRL && hwdata[DRI_CTRL_CLR];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_q <= DRI_CTRL_RST;
    else if (ph_wr_q && ph_adr_q == DRI_OFS_CTRL)
      ctrl_q <= {1'b0, hwdata[DRI_CTRL_EN]};
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================================
  // Checks
  a_term_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    !p_q.rst_n |=> !term_en_q)
    else $error("termination on during reset");

  a_term_pre_cke: assert property (@(posedge hclk) disable iff (!hresetn)
    !cke_seen_q |=> !term_en_q)
    else $error("termination on before first CKE");

  a_init_len: assert property (@(posedge hclk) disable iff (!hresetn)
    st_q == ST_WAIT_CKE && $past(st_q) == ST_INIT
    |-> $past(init_cnt_q) == DRI_INIT_W'(INIT_CYC - 1))
    else $error("initialisation wait wrong length");

  a_act_opens: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_act |=> bank_open_q[$past(p_q.ba)])
    else $error("active did not open bank");

  a_rw_closed: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_rw && !bank_open_q[p_q.ba] |=> $stable(last_col_q) && $stable(order_q))
    else $error("access to closed bank accepted");

  a_ap_closes: assert property (@(posedge hclk) disable iff (!hresetn)
    rw_ok && p_q.a[DRI_A_AP] |=> !bank_open_q[$past(p_q.ba)])
    else $error("auto precharge left bank open");

  a_mrs_banks: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_mrs && p_q.rst_n && !bank_clr |=> bank_open_q == $past(bank_open_q))
    else $error("mode write changed bank state");

  a_fix4_chop: assert property (@(posedge hclk) disable iff (!hresetn)
    rw_ok && mr_q[0][1:0] == DRI_BL_FIX4 |=> last_chop_q)
    else $error("fixed chop not applied");

endmodule // dri_init_core

// ===== sim/dri_ctrl_model.sv
`timescale 1ns/100ps
module dri_ctrl_model
  import dri_pkg::*;
#(
  parameter int TMRD = 4,
  parameter int TMOD = 12
)(
  // Pins toward the device
  output dri_pins_t pins
);
  // ==========================================================================
  // Pin state and command clock
  dri_pins_t p;
  logic      ck;
  logic      ck_run;

  initial
  begin
    ck     = 1'b0;
    ck_run = 1'b0;
    p      = '0;
    p.cs_n = 1'b1;
    p.odt  = 1'b1;
  end

  // Clock stands low until started
  always #62.5 ck = ck_run ? ~ck : 1'b0;

  always_comb
  begin
    pins    = p;
    pins.ck = ck;
  end

  // ==========================================================================
  // Reset pin, with CKE pulled low first
  task automatic set_reset(input logic lvl);
    if (!lvl)
    begin
      ck_run = 1'b0;
      p.cke  = 1'b0;
    end
    #10;
    p.rst_n = lvl;
  endtask

  // Clock first, deselects registered, then CKE
  task automatic wake();
    ck_run = 1'b1;
    repeat (6) @(posedge ck);
    @(negedge ck);
    p.cke = 1'b1;
    repeat (5) @(posedge ck);
  endtask

  // One command, then deselect with junk on released lines
  task automatic cmd(input logic [2:0] op, input logic [2:0] bank,
                     input logic [15:0] addr, input int gap);
    @(negedge ck);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = {1'b0, op};
    p.ba = bank;
    p.a  = addr;
    @(negedge ck);
    {p.cs_n, p.ras_n, p.cas_n, p.we_n} = {1'b1, ~op};
    p.ba = ~bank;
    p.a  = ~addr;
    repeat (gap) @(posedge ck);
  endtask

  // Mode registers in fixed order, then long calibration
  task automatic init_seq(input logic [3:0][15:0] mr, input logic bad);
    cmd(DRI_CMD_MRS, 3'h2, mr[2], TMRD);
    if (bad)
      cmd(DRI_CMD_MRS, 3'h6, ~mr[2], TMRD);
    cmd(DRI_CMD_MRS, 3'h3, mr[3], TMRD);
    cmd(DRI_CMD_MRS, 3'h1, {mr[1][15:1], 1'b0}, TMRD);
    cmd(DRI_CMD_MRS, 3'h0, mr[0] | 16'h0100, TMOD);
    cmd(DRI_CMD_ZQ, 3'h0, 16'h0400, 0);
  endtask
endmodule // dri_ctrl_model

// ===== sim/dri_init_core_tb.sv
`timescale 1ns/100ps
module dri_init_core_tb
  import dri_pkg::*;
;
  // ==========================================================================
  // Signals
  localparam int INIT = 200;
  localparam logic [3:0][15:0] MRV = {16'h0004, 16'h0018, 16'h0080, 16'h0070};
  typedef struct packed {
    logic [1:0]  bl;
    logic        bt;
    logic [2:0]  col;
    logic        a12;
    logic        wr;
    logic [23:0] ord;
  } dri_row_t;
  localparam dri_row_t [0:6] ROWS = '{
    '{2'h0, 1'b0, 3'h1, 1'b1, 1'b0, 24'h9f50d1},
    '{2'h0, 1'b1, 3'h5, 1'b1, 1'b0, 24'h4c1de5},
    '{2'h1, 1'b0, 3'h6, 1'b1, 1'b0, 24'h21ab3e},
    '{2'h1, 1'b1, 3'h3, 1'b0, 1'b0, 24'h000053},
    '{2'h2, 1'b0, 3'h7, 1'b1, 1'b0, 24'h000d67},
    '{2'h0, 1'b1, 3'h5, 1'b1, 1'b1, 24'hfac688},
    '{2'h1, 1'b0, 3'h6, 1'b0, 1'b1, 24'h000fac}};

  logic        hclk    = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [2:0]  hsize   = 3'h2;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  dri_pins_t   pins;
  logic        term_en_q;
  logic        dev_ready;
  logic [31:0] rd;
  dri_row_t    r;
  logic        chop;
  int          num_errors = 0;
  int          checks_done = 0;

  always #4 hclk = ~hclk;

  dri_init_core #(.INIT_CYC(INIT)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
    .term_en_q(term_en_q), .dev_ready(dev_ready));

  dri_ctrl_model u_ctrl (.pins(pins));

  // ==========================================================================
  // Bus and compare tasks
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] ad, input logic [31:0] msk,
                      input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, ad, 32'h0, v);
    chk(nm, v & msk, exp);
    chk("resp", 32'(hresp), 32'h0);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Release, wait out init, bring the device to ready
  task automatic bring_up(input logic bad);
    u_ctrl.set_reset(1'b1);
    repeat (INIT - 10) @(posedge hclk);
    rchk("init", DRI_OFS_STATUS, 32'h3f, 32'h01);
    repeat (30) @(posedge hclk);
    rchk("wait", DRI_OFS_STATUS, 32'h3f, 32'h02);
    chk("term off", 32'(term_en_q), 32'h0);
    u_ctrl.wake();
    rchk("cke", DRI_OFS_STATUS, 32'h3f, 32'h1b);
    u_ctrl.init_seq(MRV, bad);
    rchk("cal", DRI_OFS_STATUS, 32'h3f, 32'h1c);
    repeat (500) @(posedge u_ctrl.ck);
    chk("early", 32'(dev_ready), 32'h0);
    repeat (16) @(posedge u_ctrl.ck);
    rchk("ready", DRI_OFS_STATUS, 32'h3f, 32'h3d);
    for (int i = 0; i < 4; i++)
      rchk("mr", DRI_OFS_MR0 + 8'(4 * i), 32'hffff,
           {16'h0, i == 0 ? MRV[0] | 16'h0100 : MRV[i]});
    $display("done bring-up");
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    repeat (90000) @(posedge hclk);
    num_errors++;
    $display("ERROR watchdog expected finish seen timeout");
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("ctrl", DRI_OFS_CTRL, 32'h3, 32'h1);
    bus(1'b1, DRI_OFS_STATUS, 32'hffffffff, rd);
    rchk("status", DRI_OFS_STATUS, 32'h3f, 32'h0);
    rchk("unmapped", 8'h24, 32'hffffffff, 32'h0);
    $display("done reset values");
    #200000;
    bring_up(1'b1);
    for (int i = 0; i < 7; i++)
    begin
      r = ROWS[i];
      chop = (r.bl == DRI_BL_FIX4) || (r.bl == DRI_BL_OTF && !r.a12);
      u_ctrl.cmd(DRI_CMD_PRE, 3'h0, 16'h0400, 2);
      u_ctrl.cmd(DRI_CMD_MRS, 3'h0, {12'h0, r.bt, 1'b0, r.bl}, 12);
      u_ctrl.cmd(DRI_CMD_ACT, 3'h3, 16'h1234, 2);
      u_ctrl.cmd(r.wr ? DRI_CMD_WR : DRI_CMD_RD, 3'h3,
                 {3'h0, r.a12, 1'b0, r.wr, 7'h15, r.col}, 2);
      rchk("mr0", DRI_OFS_MR0, 32'hffff, {28'h0, r.bt, 1'b0, r.bl});
      rchk("order", DRI_OFS_ORDER, chop ? 32'hfff : 32'hffffff, {8'h0, r.ord});
      rchk("flags", DRI_OFS_STATUS, 32'hc0, {24'h0, r.wr, chop, 6'h0});
      rchk("last", DRI_OFS_LAST, 32'h73ffffff, {4'h3, 2'h0, 7'h15, r.col, 16'h1234});
    end
    chk("still ready", 32'(dev_ready), 32'h1);
    $display("done burst rows");
    u_ctrl.cmd(DRI_CMD_PRE, 3'h0, 16'h0400, 2);
    u_ctrl.cmd(DRI_CMD_RD, 3'h5, 16'h0000, 2);
    rchk("closed", DRI_OFS_LAST, 32'h70000000, 32'h30000000);
    u_ctrl.cmd(DRI_CMD_ACT, 3'h0, 16'h0001, 2);
    u_ctrl.cmd(DRI_CMD_ACT, 3'h7, 16'h0002, 2);
    rchk("open", DRI_OFS_BANK, 32'hff, 32'h81);
    u_ctrl.cmd(DRI_CMD_PRE, 3'h0, 16'h0000, 2);
    rchk("pre one", DRI_OFS_BANK, 32'hff, 32'h80);
    bus(1'b1, DRI_OFS_CTRL, 32'h3, rd);
    rchk("cleared", DRI_OFS_BANK, 32'hff, 32'h0);
    rchk("ctrl", DRI_OFS_CTRL, 32'h3, 32'h1);
    bus(1'b1, DRI_OFS_CTRL, 32'h0, rd);
    u_ctrl.cmd(DRI_CMD_ACT, 3'h2, 16'h0003, 2);
    rchk("disabled", DRI_OFS_BANK, 32'hff, 32'h0);
    bus(1'b1, DRI_OFS_CTRL, 32'h1, rd);
    u_ctrl.cmd(DRI_CMD_ACT, 3'h2, 16'h0003, 2);
    rchk("enabled", DRI_OFS_BANK, 32'hff, 32'h04);
    u_ctrl.cmd(DRI_CMD_PRE, 3'h0, 16'h0400, 2);
    rchk("pre all", DRI_OFS_BANK, 32'hff, 32'h0);
    $display("done banks");
    u_ctrl.set_reset(1'b0);
    #100;
    rchk("warm", DRI_OFS_STATUS, 32'h3f, 32'h0);
    chk("warm ready", 32'(dev_ready), 32'h0);
    bring_up(1'b0);
    summarize();
  end
endmodule // dri_init_core_tb
